// [display_reset_and_bus_select.sv]
// reset handling, blanking, stored-settings reload and host bus mode select
// assumes pins are synchronous to clk; the host keeps its own wait times
`timescale 1ns/1ps
module display_reset_and_bus_select
   import reset_seq_pkg::*;
#(
   parameter int unsigned reload_cycles = reload_cycles_dflt,
   parameter int unsigned blank_cycles = blank_cycles_dflt
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hw_reset_n,
   input wire logic host_bus_select,
   input wire logic serial_wire_count_select,
   input wire logic sleep_in,
   input wire logic [word_w-1:0] stored_settings_data,
   output logic [idx_w-1:0] stored_settings_addr,
   output logic stored_settings_read,
   output bus_mode_t bus_mode,
   output seq_status_t status,
   output logic [word_w*reload_words-1:0] settings
);
   logic start;
   logic confirmed;
   logic released;
   logic confirmed_seen;
   logic read_pending;
   logic [cnt_w-1:0] blank_cnt;
   logic [cnt_w-1:0] wait_cnt;
   seq_state_t state;
   seq_state_t next_state;

   reset_glitch_filter filter (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(hw_reset_n),
      .start(start),
      .confirmed(confirmed),
      .released(released)
   );

   // bus mode follows the static select pins; serial width only matters when serial
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_mode <= '0;
      end else begin
         bus_mode.parallel <= host_bus_select;
         bus_mode.four_wire <= !host_bus_select && serial_wire_count_select;
      end
   end

   // a release only counts as a full reset once the low run passed the long limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         confirmed_seen <= 1'b0;
      end else if (start) begin
         confirmed_seen <= 1'b0;
      end else if (confirmed) begin
         confirmed_seen <= 1'b1;
      end
   end

   // sequencer state
   always_comb begin
      next_state = state;
      case (state)
         st_run, st_ready: begin
            if (start) begin
               next_state = sleep_in ? st_held : st_blank;
            end
         end
         st_blank: begin
            // a release inside the blanking time must not be lost, so it ends blanking early
            if (released) begin
               next_state = st_reload;
            end else if (blank_cnt == cnt_w'(blank_cycles - 1)) begin
               next_state = st_held;
            end
         end
         st_held: begin
            if (released) begin
               next_state = st_reload;
            end
         end
         st_reload: begin
            if (!read_pending && stored_settings_addr == idx_last && !stored_settings_read) begin
               next_state = st_ready;
            end
         end
         default: next_state = st_run;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_run;
      end else begin
         state <= next_state;
      end
   end

   // blanking timer; stopping early on release still keeps it under the limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blank_cnt <= cnt_zero;
      end else if (state == st_blank) begin
         blank_cnt <= blank_cnt + 1'b1;
      end else begin
         blank_cnt <= cnt_zero;
      end
   end

   // reload walk: one word per two cycles, far below the reload budget
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stored_settings_addr <= idx_zero;
         stored_settings_read <= 1'b0;
         read_pending <= 1'b0;
      end else if (state != st_reload) begin
         stored_settings_addr <= idx_zero;
         stored_settings_read <= next_state == st_reload;
         read_pending <= next_state == st_reload;
      end else if (stored_settings_read) begin
         stored_settings_read <= 1'b0;
      end else if (read_pending) begin
         read_pending <= stored_settings_addr != idx_last;
         stored_settings_read <= stored_settings_addr != idx_last;
         if (stored_settings_addr != idx_last) begin
            stored_settings_addr <= stored_settings_addr + 1'b1;
         end
      end
   end

   // settings go to defaults at reset start, then take the stored words
   generate
      for (genvar i = 0; i < reload_words; i++) begin : g_word
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               settings[i*word_w +: word_w] <= settings_default;
            end else if (start && (state == st_run || state == st_ready)) begin
               settings[i*word_w +: word_w] <= settings_default;
            end else if (state == st_reload && read_pending && !stored_settings_read
                         && stored_settings_addr == idx_w'(i)) begin
               settings[i*word_w +: word_w] <= stored_settings_data;
            end
         end
      end
   endgenerate

   // counts the host's command wait after release; cmd_ready waits for it to reach reload_cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt <= cnt_zero;
      end else if (state == st_held || state == st_blank) begin
         wait_cnt <= cnt_zero;
      end else if (wait_cnt != cnt_w'(reload_cycles)) begin
         wait_cnt <= wait_cnt + 1'b1; // host command wait point
      end
   end

   // status flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         status.busy <= next_state == st_blank || next_state == st_held || next_state == st_reload;
         status.blank <= next_state == st_blank || next_state == st_held || next_state == st_reload;
         status.reload_done <= next_state == st_ready && confirmed_seen;
         status.cmd_ready <= next_state != st_blank && next_state != st_held && next_state != st_reload
                             && wait_cnt == cnt_w'(reload_cycles);
      end
   end
endmodule

// [display_reset_chk.sv]
// assertions on reset filtering, reload reads and bus mode
// assumes pins sync to clk; bound to the top module below
`timescale 1ns/1ps
module display_reset_chk
   import reset_seq_pkg::*;
#(
   parameter int unsigned reload_cycles = reload_cycles_dflt
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hw_reset_n,
   input wire logic host_bus_select,
   input wire logic serial_wire_count_select,
   input wire logic sleep_in,
   input wire logic [word_w-1:0] stored_settings_data,
   input wire logic [idx_w-1:0] stored_settings_addr,
   input wire logic stored_settings_read,
   input wire bus_mode_t bus_mode,
   input wire seq_status_t status,
   input wire logic [word_w*reload_words-1:0] settings
);
   localparam int done_at = 250 + reload_cycles + 40;
   logic [15:0] low_cnt;
   logic [15:0] high_cnt;
   logic low_seen;
   // pin run lengths; saturate so long idle spells cannot wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= '0;
         high_cnt <= '0;
      end else begin
         low_cnt <= hw_reset_n ? '0 : low_cnt + {15'h0000, ~&low_cnt};
         high_cnt <= hw_reset_n ? high_cnt + {15'h0000, ~&high_cnt} : '0;
      end
   end
   // remembers that a full-length reset has been seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_seen <= 1'b0;
      end else if (low_cnt == 16'h01cc) begin
         low_seen <= 1'b1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence calm_sel;
      ($stable(host_bus_select) && $stable(serial_wire_count_select)) [*4];
   endsequence
   sequence word_fetch;
      stored_settings_read ##1 1'b1;
   endsequence
   chk_bus_parallel: assert property (calm_sel |-> bus_mode.parallel == host_bus_select)
      else $error("parallel bit does not follow select");
   chk_bus_wires: assert property (calm_sel |->
      bus_mode.four_wire == (serial_wire_count_select && !host_bus_select))
      else $error("wire count bit wrong");
   chk_glitch_ignored: assert property ($rose(hw_reset_n) && low_cnt < 240 &&
      !status.busy |-> !status.busy [*3])
      else $error("short low pulse started a reset");
   chk_full_reset: assert property (low_cnt == 300 |-> status.busy && status.blank)
      else $error("long low pulse not taken as reset");
   chk_blank_holds: assert property ($rose(status.blank) && !sleep_in |-> status.blank [*8])
      else $error("blanking cut short");
   chk_read_release: assert property (stored_settings_read |-> hw_reset_n && high_cnt >= 249)
      else $error("reload read before release");
   chk_read_pulse: assert property (stored_settings_read |=> !stored_settings_read)
      else $error("read pulse longer than one cycle");
   chk_word_capture: assert property (word_fetch |=>
      settings[8*$past(stored_settings_addr, 2) +: 8] == $past(stored_settings_data))
      else $error("fetched word not stored");
   chk_reload_bound: assert property (low_seen && high_cnt == done_at |-> status.cmd_ready && !status.busy)
      else $error("reload not finished in time");
endmodule
bind display_reset_and_bus_select display_reset_chk #(.reload_cycles(reload_cycles)) chk_u (.clk, .rst_n,
   .hw_reset_n, .host_bus_select, .serial_wire_count_select, .sleep_in, .stored_settings_data,
   .stored_settings_addr, .stored_settings_read, .bus_mode, .status, .settings);

// [reset_glitch_filter.sv]
// filter for the active-low reset pin: rejects short lows, confirms long ones
// assumes the pin is already synchronous to clk
`timescale 1ns/1ps
module reset_glitch_filter
   import reset_seq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_n,
   output logic start,
   output logic confirmed,
   output logic released
);
   logic [flt_w-1:0] low_cnt;
   logic [flt_w-1:0] high_cnt;
   logic held;

   // count the length of the present low run; a high resets it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= flt_zero;
      end else if (pin_n) begin
         low_cnt <= flt_zero;
      end else if (low_cnt != flt_w'(full_cycles)) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // highs within a held reset shorter than the reject time are spikes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_cnt <= flt_zero;
      end else if (!pin_n || !held) begin
         high_cnt <= flt_zero;
      end else if (high_cnt != flt_w'(reject_cycles)) begin
         high_cnt <= high_cnt + 1'b1;
      end
   end

   // one-cycle events plus the held level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held <= 1'b0;
         start <= 1'b0;
         confirmed <= 1'b0;
         released <= 1'b0;
      end else begin
         start <= !held && !pin_n && low_cnt == flt_w'(reject_cycles - 1);
         confirmed <= !pin_n && low_cnt == flt_w'(full_cycles - 1);
         released <= held && pin_n && high_cnt == flt_w'(reject_cycles - 1);
         if (!pin_n && low_cnt == flt_w'(reject_cycles - 1)) begin
            held <= 1'b1;
         end else if (pin_n && high_cnt == flt_w'(reject_cycles - 1)) begin
            held <= 1'b0;
         end
      end
   end
endmodule

// [reset_seq_pkg.sv]
// constants, types and state encoding shared by the reset and bus-select logic
// assumes a single 50 MHz clock and pins already synchronous to it
// Notes on behaviour
// - select pin low serial, high parallel
// - wire select low 3-line, high 4-line
// - reject under 5us, reset over 9us
// - spikes during held reset are ignored
// - reload stored settings on each release
// - reload finishes within 5 ms of release
// - awake reset runs blanking up to 120 ms
// - sleeping reset keeps display blank only
// - settings return to defaults at reset start
package reset_seq_pkg;
   localparam int unsigned clk_hz = 50_000_000;
   localparam int unsigned reject_us = 5;
   localparam int unsigned full_us = 9;
   localparam int unsigned reload_ms = 5;
   localparam int unsigned blank_ms = 120;
   // least and longest times both round down, as the integer divisions truncate
   localparam int unsigned reject_cycles = (reject_us * (clk_hz / 1_000_000));
   localparam int unsigned full_cycles = (full_us * (clk_hz / 1_000_000));
   localparam int unsigned reload_cycles_dflt = reload_ms * (clk_hz / 1000);
   localparam int unsigned blank_cycles_dflt = blank_ms * (clk_hz / 1000);
   localparam int cnt_w = 23;
   localparam int flt_w = 9;
   localparam int word_w = 8;
   localparam int reload_words = 4;
   localparam int idx_w = 2;
   localparam logic [word_w-1:0] settings_default = 8'h00;
   localparam logic [flt_w-1:0] flt_zero = 9'h000;
   localparam logic [cnt_w-1:0] cnt_zero = 23'h000000;
   localparam logic [idx_w-1:0] idx_zero = 2'h0;
   localparam logic [idx_w-1:0] idx_last = 2'h3;

   typedef enum logic [2:0] {
      st_run = 3'b000,
      st_blank = 3'b001,
      st_held = 3'b011,
      st_reload = 3'b010,
      st_ready = 3'b110
   } seq_state_t;

   typedef struct packed {
      logic parallel;
      logic four_wire;
   } bus_mode_t;

   typedef struct packed {
      logic busy;
      logic blank;
      logic reload_done;
      logic cmd_ready;
   } seq_status_t;
endpackage

// [settings_memory_model.sv]
// host-side model of the stored settings memory
// assumes read and address change just after clk rising edges
`timescale 1ns/1ps
module settings_memory_model
   import reset_seq_pkg::*;
(
   input wire logic clk,
   input wire logic [word_w*reload_words-1:0] words,
   input wire logic [idx_w-1:0] addr,
   input wire logic read,
   output logic [word_w-1:0] data
);
   initial data = 8'h5a;
   // word valid one cycle after a read, toggles otherwise so a late sample shows
   always @(posedge clk) begin
      if (read) begin
         data <= words[8*addr +: 8];
      end else begin
         data <= ~data;
      end
   end
endmodule

// [test_display_reset_and_bus_select.sv]
// bench for pin filtering, blanking, reload and bus mode
// assumes the memory model answers reloads; long counts scaled down
`timescale 1ns/1ps
module test_display_reset_and_bus_select;
   import reset_seq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hw_reset_n = 1'b1;
   logic host_bus_select = 1'b0;
   logic serial_wire_count_select = 1'b0;
   logic sleep_in = 1'b0;
   logic ready_seen = 1'b0;
   logic [7:0] lfsr = 8'h1c;
   logic [31:0] words = 32'h00000000;
   logic [7:0] mem_data;
   logic [1:0] mem_addr;
   logic mem_read;
   bus_mode_t bus_mode;
   seq_status_t status;
   logic [31:0] settings;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int total_checks = 0;
   initial forever #10 clk = ~clk;
   display_reset_and_bus_select #(.reload_cycles(20), .blank_cycles(30)) dut_u (.clk(clk), .rst_n(rst_n),
      .hw_reset_n(hw_reset_n), .host_bus_select(host_bus_select),
      .serial_wire_count_select(serial_wire_count_select), .sleep_in(sleep_in),
      .stored_settings_data(mem_data), .stored_settings_addr(mem_addr), .stored_settings_read(mem_read),
      .bus_mode(bus_mode), .status(status), .settings(settings));
   settings_memory_model mem_u (.clk(clk), .words(words), .addr(mem_addr), .read(mem_read), .data(mem_data));
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task automatic pin(input logic v, input int n);
      hw_reset_n = v;
      repeat (n) @(negedge clk);
   endtask
   // held reset with a short high spike, then release and bounded wait
   task automatic long_reset(input logic slp);
      int n;
      sleep_in = slp;
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         words[8*i +: 8] = lfsr;
      end
      exp_q.push_back(words);
      // held past the full-reset limit so the reload is flagged as done
      pin(1'b0, 500);
      cmp_bit(status.blank, 1'b1, "display not blank in reset");
      cmp_word(settings, 32'h00000000, "settings not at default in reset");
      pin(1'b1, 100);
      pin(1'b0, 100);
      cmp_bit(status.busy, 1'b1, "spike ended reset");
      pin(1'b1, 1);
      n = 0;
      while (status.cmd_ready !== 1'b1 && n < 2000) begin
         n++;
         @(negedge clk);
      end
      cmp_bit(n < 2000, 1'b1, "no ready after reload");
      if (n >= 2000) report_and_stop();
      // wake only after the scaled wake wait has passed
      repeat (30) @(negedge clk);
      sleep_in = 1'b0;
   endtask
   // oldest expected word is compared on each rise of reload done, not on the first ready after power-up
   always @(posedge clk) begin
      ready_seen <= status.reload_done;
      if (status.reload_done === 1'b1 && ready_seen !== 1'b1 && exp_q.size() > 0) begin
         cmp_word(settings, exp_q.pop_front(), "reloaded settings");
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         {host_bus_select, serial_wire_count_select} = i[1:0];
         repeat (5) @(negedge clk);
         cmp_bit(bus_mode.parallel, i[1], "parallel select");
         cmp_bit(bus_mode.four_wire, i[0] & ~i[1], "wire count select");
      end
      long_reset(1'b0);
      pin(1'b0, 200);
      pin(1'b1, 10);
      cmp_bit(status.busy, 1'b0, "glitch taken as reset");
      long_reset(1'b1);
      cmp_bit(exp_q.size() == 0, 1'b1, "reload count");
      report_and_stop();
   end
endmodule
